// File: verilog/pmc_params.svh
// constants for the power mode and clock control block
// Operation
// - external clock selected: amplifier off, system clock taken from oscillator input pin.
// - with external clock, output pin is unused, port 4 bit 7, or divided clock.
// - idle keeps timers and serial port running unless their own enables are cleared.
// - watchdog runs or halts in idle per the watchdog idle enable bit.
// - brown-out detector stays active throughout idle.
// - idle ends on any enabled interrupt or any reset.
// - interrupt wake from idle services it at once, then resumes after idle instruction.
// - clock divider changes the clock of every peripheral.
// - power control register at 87H, not bit addressable, resets 000X 0000.
// - bit 7 doubles serial baud rate in modes 1, 2 and 3.
// - bit 6 picks serial control bit 7 view; frame error always sets.
// - bit 5 picks power-down wake: 0 external, 1 internally timed.
// - bit 4 set by cold power-up, software read/write, kept by warm resets.
// - bits 3 and 2 are plain software flags.
// - writing bit 1 enters power-down; hardware clears it on wake.
// - writing bit 0 enters idle; hardware clears it on wake.
// - power-down stops oscillator, disables brown-out detector, powers down flash.
// - internal RAM is kept during power-down.
// - power-down exits only on external reset, power-on reset or enabled interrupts.
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
`define PMC_POWER_CONTROL_ADDR 8'h87
`define PMC_POWER_CONTROL_RESET 8'h00
`define PMC_BIT_BAUD 7
`define PMC_BIT_FESEL 6
`define PMC_BIT_PDEXIT 5
`define PMC_BIT_COLD 4
`define PMC_BIT_GFH 3
`define PMC_BIT_GFL 2
`define PMC_BIT_PD 1
`define PMC_BIT_IDLE 0
`define PMC_CLK_MHZ 100
`define PMC_WAKE_TIME_NS 1000
`define PMC_WAKE_CYCLES ((`PMC_WAKE_TIME_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_DIV_W 4
`endif

// File: verilog/pmc_pkg.sv
// types of the power mode and clock control block
package pmc_pkg;
    typedef enum logic [3:0] {
        PMC_RUN = 4'h1,
        PMC_IDLE = 4'h2,
        PMC_PDOWN = 4'h4,
        PMC_WAKE = 4'h8
    } pmc_state_t;
    typedef enum logic [1:0] {
        PMC_SRC_XTAL = 2'h0,
        PMC_SRC_EXT = 2'h1,
        PMC_SRC_RC = 2'h2
    } pmc_src_t;
endpackage : pmc_pkg

// File: verilog/pmc_clk_if.sv
// clock selection and gating signals between the control core and clock unit
`timescale 1ns/1ns
interface pmc_clk_if;
    logic osc_run;
    logic core_gate;
    logic periph_gate;
    logic [1:0] src;
    logic [3:0] div;
    logic sys_tick;
    logic div_clk;
    modport ctrl (output osc_run, output core_gate, output periph_gate, output src,
        output div, input sys_tick, input div_clk);
    modport clk (input osc_run, input core_gate, input periph_gate, input src,
        input div, output sys_tick, output div_clk);
endinterface : pmc_clk_if

// File: verilog/pmc_clk_unit.sv
// clock source selection, system divider and gate enables
`timescale 1ns/1ns
`include "pmc_params.svh"
module pmc_clk_unit (
    input wire core_clk, // system clock
    input wire rst, // async reset, high
    pmc_clk_if.clk ci, // control side
    output logic amp_en, // oscillator amplifier enable
    output logic core_en, // core clock enable
    output logic periph_en // peripheral clock enable
);
    logic [`PMC_DIV_W-1:0] div_cnt;
    logic div_clk_q;
    wire div_hit = (div_cnt >= ci.div);
    wire [`PMC_DIV_W-1:0] next_div_cnt = div_hit ? '0 : div_cnt + 1'b1;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_cnt <= '0;
            div_clk_q <= 1'b0;
        end else begin
            div_cnt <= ci.osc_run ? next_div_cnt : '0;
            div_clk_q <= (ci.osc_run && div_hit) ? ~div_clk_q : div_clk_q;
        end
    end
    // one tick drives core and peripherals alike, so the divider moves all of them
    assign ci.sys_tick = ci.osc_run && div_hit;
    assign ci.div_clk = div_clk_q;
    // only the crystal source needs the amplifier
    assign amp_en = ci.osc_run && (ci.src == 2'(pmc_pkg::PMC_SRC_XTAL));
    assign core_en = ci.sys_tick && ci.core_gate;
    assign periph_en = ci.sys_tick && ci.periph_gate;
endmodule : pmc_clk_unit

// File: verilog/pmc_wake_timer.sv
// internally timed wake-up delay after power-down
`timescale 1ns/1ns
`include "pmc_params.svh"
module pmc_wake_timer (
    input wire core_clk, // system clock
    input wire rst, // async reset, high
    input wire start, // pulse, begin timing
    output logic done // pulse, delay elapsed
);
    localparam int unsigned WAKE_N = `PMC_WAKE_CYCLES;
    logic [15:0] cnt;
    logic busy;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= 16'h0000;
            busy <= 1'b0;
        end else if (start) begin
            cnt <= 16'(WAKE_N - 1);
            busy <= 1'b1;
        end else if (busy) begin
            cnt <= cnt - 16'h0001;
            busy <= (cnt != 16'h0000);
        end
    end
    assign done = busy && (cnt == 16'h0000);
endmodule : pmc_wake_timer

// File: verilog/pmc_power_ctrl.sv
// power control register, idle and power-down sequencing, clock routing
`timescale 1ns/1ns
`include "pmc_params.svh"
module pmc_power_ctrl (
    input wire core_clk, // system clock
    input wire rst, // warm reset (pin or brown-out), async high
    input wire por_rst, // power-on reset, async high
    input wire [7:0] sfr_addr, // special-function address
    input wire [7:0] sfr_wdata, // write data
    input wire sfr_wr, // write strobe, one cycle
    input wire sfr_rd, // read strobe, one cycle
    output logic [7:0] sfr_rdata, // read data, registered
    output logic sfr_hit, // address decodes to this block
    input wire irq_pending, // enabled interrupt requested
    input wire pd_wake_irq, // enabled wake-capable interrupt
    input wire ext_wake_pin, // external wake release, async
    input wire frame_error, // serial frame error event, pulse
    input wire serial_mode0, // serial mode bit zero from serial control
    input wire [1:0] serial_mode, // current serial mode
    input wire [1:0] clk_src, // source select: 0 crystal, 1 external, 2 rc
    input wire [3:0] clk_div, // system clock divider setting
    input wire port4_ovr_en, // output pin used as port 4 bit 7
    input wire port4_b7_out, // port 4 bit 7 output value
    input wire clk_out_en, // output pin drives divided clock
    input wire watchdog_idle_enable, // watchdog runs during idle
    input wire frame_err_clr, // software clears frame error flag
    output logic serial_control_reg_bit7, // serial control bit 7 view, registered
    output logic frame_error_flag, // sticky frame error flag
    output logic baud_double, // double serial baud rate
    output logic amp_en, // oscillator amplifier enable
    output logic core_en, // core clock enable
    output logic periph_en, // peripheral clock enable
    output logic watchdog_en, // watchdog clock enable
    output logic brownout_detector_en, // brown-out detector enable
    output logic flash_pwr_en, // flash memory power
    output logic ram_retain, // keep internal ram alive
    output logic irq_service_now, // wake interrupt to serve at once
    output logic osc_out_pin_o, // oscillator output pin drive value
    output logic osc_out_pin_oe_n, // low while driving the output pin
    output logic osc_in_is_gpio, // oscillator input pin free as port 4 bit 6
    output logic osc_out_is_gpio, // oscillator output pin free as port 4 bit 7
    output pmc_pkg::pmc_state_t pmc_state // current power state
);
    pmc_clk_if ci();
    logic baud_dbl;
    logic fe_sel;
    logic pd_exit_timed;
    logic cold_start_flag;
    logic general_flag_high;
    logic general_flag_low;
    logic powerdown_request;
    logic idle_request;
    logic fe_q;
    logic [7:0] rdata_q;
    logic scon7_q;
    logic wake_s1;
    logic wake_s2;
    logic wake_s3;
    logic wake_done;
    logic svc_q;
    pmc_pkg::pmc_state_t state;
    pmc_pkg::pmc_state_t next_state;
    wire sel = (sfr_addr == `PMC_POWER_CONTROL_ADDR);
    wire wr_en = sfr_wr && sel;
    wire rd_en = sfr_rd && sel;
    wire [7:0] power_control_view = {baud_dbl, fe_sel, pd_exit_timed, cold_start_flag,
        general_flag_high, general_flag_low, powerdown_request, idle_request};
    wire in_idle = (state == pmc_pkg::PMC_IDLE);
    wire in_pd = (state == pmc_pkg::PMC_PDOWN);
    wire in_wake = (state == pmc_pkg::PMC_WAKE);
    wire idle_exit = in_idle && irq_pending;
    wire pd_wake_ext = in_pd && !pd_exit_timed && (wake_s2 && !wake_s3);
    wire pd_wake_int = in_pd && pd_exit_timed && pd_wake_irq;
    wire pd_exit = pd_wake_ext || pd_wake_int;
    wire wake_start = pd_exit;
    wire wake_finish = in_wake && wake_done;
    wire src_ext = (clk_src == 2'(pmc_pkg::PMC_SRC_EXT));
    wire src_rc = (clk_src == 2'(pmc_pkg::PMC_SRC_RC));
    wire next_fe = frame_error | (fe_q & ~frame_err_clr);
    wire uart_doubles = (serial_mode != 2'h0);
    always_comb begin
        next_state = state;
        case (state)
            pmc_pkg::PMC_RUN: begin
                if (powerdown_request) next_state = pmc_pkg::PMC_PDOWN;
                else if (idle_request) next_state = pmc_pkg::PMC_IDLE;
            end
            pmc_pkg::PMC_IDLE: begin
                if (idle_exit) next_state = pmc_pkg::PMC_RUN;
            end
            pmc_pkg::PMC_PDOWN: begin
                if (pd_exit) next_state = pmc_pkg::PMC_WAKE;
            end
            pmc_pkg::PMC_WAKE: begin
                if (wake_finish) next_state = pmc_pkg::PMC_RUN;
            end
            default: next_state = pmc_pkg::PMC_RUN;
        endcase
    end
    // any warm or cold reset leaves idle or power-down
    always_ff @(posedge core_clk or posedge rst or posedge por_rst) begin
        if (rst || por_rst) state <= pmc_pkg::PMC_RUN;
        else state <= next_state;
    end
    // cold start flag only follows the power-on reset, warm resets leave it
    always_ff @(posedge core_clk or posedge por_rst) begin
        if (por_rst) cold_start_flag <= 1'b1;
        else if (wr_en) cold_start_flag <= sfr_wdata[`PMC_BIT_COLD];
    end
    always_ff @(posedge core_clk or posedge rst or posedge por_rst) begin
        if (rst || por_rst) begin
            baud_dbl <= 1'b0;
            fe_sel <= 1'b0;
            pd_exit_timed <= 1'b0;
            general_flag_high <= 1'b0;
            general_flag_low <= 1'b0;
        end else if (wr_en) begin
            baud_dbl <= sfr_wdata[`PMC_BIT_BAUD];
            fe_sel <= sfr_wdata[`PMC_BIT_FESEL];
            pd_exit_timed <= sfr_wdata[`PMC_BIT_PDEXIT];
            general_flag_high <= sfr_wdata[`PMC_BIT_GFH];
            general_flag_low <= sfr_wdata[`PMC_BIT_GFL];
        end
    end
    // hardware clear on wake; a write in the same cycle is ignored since the core is stopped
    always_ff @(posedge core_clk or posedge rst or posedge por_rst) begin
        if (rst || por_rst) begin
            powerdown_request <= 1'b0;
            idle_request <= 1'b0;
        end else if (wake_finish) begin
            powerdown_request <= 1'b0;
        end else if (idle_exit) begin
            idle_request <= 1'b0;
        end else if (wr_en) begin
            powerdown_request <= sfr_wdata[`PMC_BIT_PD];
            idle_request <= sfr_wdata[`PMC_BIT_IDLE];
        end
    end
    // frame error sets whatever the select bit says; set wins over clear
    always_ff @(posedge core_clk or posedge rst or posedge por_rst) begin
        if (rst || por_rst) fe_q <= 1'b0;
        else fe_q <= next_fe;
    end
    always_ff @(posedge core_clk or posedge rst or posedge por_rst) begin
        if (rst || por_rst) begin
            rdata_q <= 8'h00;
            scon7_q <= 1'b0;
            svc_q <= 1'b0;
        end else begin
            rdata_q <= rd_en ? power_control_view : 8'h00;
            scon7_q <= fe_sel ? fe_q : serial_mode0;
            svc_q <= idle_exit || wake_finish;
        end
    end
    // wake release pin is asynchronous; edge is taken after the second stage only
    always_ff @(posedge core_clk or posedge rst or posedge por_rst) begin
        if (rst || por_rst) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
            wake_s3 <= 1'b0;
        end else begin
            wake_s1 <= ext_wake_pin;
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
        end
    end
    wire timer_done;
    pmc_wake_timer u_wake (
        .core_clk(core_clk),
        .rst(rst | por_rst),
        .start(wake_start),
        .done(timer_done)
    );
    // external wake needs no timed delay once the pin has released
    assign wake_done = pd_exit_timed ? timer_done : 1'b1;
    assign ci.osc_run = !in_pd;
    assign ci.core_gate = (state == pmc_pkg::PMC_RUN);
    assign ci.periph_gate = !in_pd && !in_wake;
    assign ci.src = clk_src;
    assign ci.div = clk_div;
    pmc_clk_unit u_clk (
        .core_clk(core_clk),
        .rst(rst | por_rst),
        .ci(ci.clk),
        .amp_en(amp_en),
        .core_en(core_en),
        .periph_en(periph_en)
    );
    assign sfr_hit = sel;
    assign sfr_rdata = rdata_q;
    assign serial_control_reg_bit7 = scon7_q;
    assign frame_error_flag = fe_q;
    assign baud_double = baud_dbl && uart_doubles;
    assign watchdog_en = ci.sys_tick && (!in_idle || watchdog_idle_enable) && !in_pd;
    assign brownout_detector_en = !in_pd && !in_wake;
    assign flash_pwr_en = !in_pd;
    assign ram_retain = 1'b1;
    assign irq_service_now = svc_q;
    assign osc_in_is_gpio = src_rc;
    // rc source frees the output pin outright; external clock only on request
    assign osc_out_is_gpio = src_rc || (src_ext && port4_ovr_en);
    assign osc_out_pin_o = clk_out_en ? ci.div_clk : port4_b7_out;
    assign osc_out_pin_oe_n = !((src_ext || src_rc) && (clk_out_en || port4_ovr_en));
    assign pmc_state = state;
endmodule : pmc_power_ctrl

// File: bench/pmc_power_ctrl_assertions.sv
// port checks of the power control block
`timescale 1ns/1ns
module pmc_power_ctrl_sva (
    input wire core_clk, // clock
    input wire rst, // warm reset
    input wire por_rst, // cold reset
    input wire [7:0] sfr_addr, // address
    input wire sfr_rd, // read strobe
    input wire [7:0] sfr_rdata, // read data
    input wire sfr_hit, // decode
    input wire irq_pending, // idle wake
    input wire pd_wake_irq, // power-down wake
    input wire ext_wake_pin, // pin wake
    input wire [1:0] serial_mode, // serial mode
    input wire [1:0] clk_src, // clock source
    input wire watchdog_idle_enable, // watchdog in idle
    input wire baud_double, // baud doubling
    input wire amp_en, // amplifier
    input wire core_en, // core clock
    input wire periph_en, // peripheral clock
    input wire watchdog_en, // watchdog clock
    input wire brownout_detector_en, // brown-out
    input wire flash_pwr_en, // flash power
    input wire ram_retain, // ram keep
    input wire irq_service_now, // serve pulse
    input wire osc_in_is_gpio, // input pin free
    input wire osc_out_is_gpio, // output pin free
    input pmc_pkg::pmc_state_t pmc_state // power state
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst || por_rst);
    sequence idle_exit;
        pmc_state == pmc_pkg::PMC_IDLE ##1 pmc_state == pmc_pkg::PMC_RUN;
    endsequence
    a_hit_decode: assert property (sfr_hit == (sfr_addr == 8'h87))
        else $error("decode mismatch");
    a_read_unmapped: assert property (sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_idle_gates_core: assert property (pmc_state == pmc_pkg::PMC_IDLE |-> !core_en && periph_en)
        else $error("idle gating wrong");
    a_idle_keeps_bod: assert property (pmc_state == pmc_pkg::PMC_IDLE
        |-> brownout_detector_en && watchdog_en == watchdog_idle_enable)
        else $error("idle bod or watchdog wrong");
    a_idle_irq_exit: assert property (pmc_state == pmc_pkg::PMC_IDLE && irq_pending
        |=> pmc_state == pmc_pkg::PMC_RUN)
        else $error("idle not left on irq");
    a_wake_serve: assert property (idle_exit |-> irq_service_now)
        else $error("no serve pulse");
    a_pdown_off: assert property (pmc_state == pmc_pkg::PMC_PDOWN
        |-> !brownout_detector_en && !flash_pwr_en && !amp_en && ram_retain)
        else $error("power-down enables wrong");
    a_pdown_hold: assert property (pmc_state == pmc_pkg::PMC_PDOWN && !pd_wake_irq
        && !irq_pending && !ext_wake_pin && !$past(ext_wake_pin) && !$past(ext_wake_pin, 2)
        && !$past(ext_wake_pin, 3) |=> pmc_state == pmc_pkg::PMC_PDOWN)
        else $error("power-down left without cause");
    a_ext_no_amp: assert property (clk_src == 2'h1 |-> !amp_en)
        else $error("amplifier on with external clock");
    a_rc_frees_pins: assert property (clk_src == 2'h2 |-> osc_in_is_gpio && osc_out_is_gpio)
        else $error("pins not freed");
    a_baud_modes: assert property (baud_double |-> serial_mode != 2'h0)
        else $error("baud doubled in mode 0");
endmodule : pmc_power_ctrl_sva
bind pmc_power_ctrl pmc_power_ctrl_sva u_sva (.core_clk, .rst, .por_rst, .sfr_addr, .sfr_rd,
    .sfr_rdata, .sfr_hit, .irq_pending, .pd_wake_irq, .ext_wake_pin, .serial_mode, .clk_src,
    .watchdog_idle_enable, .baud_double, .amp_en, .core_en, .periph_en, .watchdog_en,
    .brownout_detector_en, .flash_pwr_en, .ram_retain, .irq_service_now, .osc_in_is_gpio,
    .osc_out_is_gpio, .pmc_state);

// File: bench/pmc_far_model.sv
// interrupt side model: raises a wake cause after a chosen lag
`timescale 1ns/1ns
module pmc_far_model (
    input wire core_clk, // clock
    input wire rst, // reset
    input pmc_pkg::pmc_state_t pmc_state, // device state
    input wire [1:0] wake_kind, // 0 none 1 irq 2 pin 3 pd irq
    input wire [3:0] lag, // cycles asleep before waking
    output logic irq_pending, // enabled interrupt
    output logic pd_wake_irq, // wake interrupt
    output logic ext_wake_pin // wake pin
);
    logic [3:0] cnt;
    wire asleep = (pmc_state == pmc_pkg::PMC_IDLE) || (pmc_state == pmc_pkg::PMC_PDOWN);
    wire fire = asleep && (cnt == lag);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            {irq_pending, ext_wake_pin, pd_wake_irq} <= 3'h0;
        end else begin
            cnt <= asleep ? cnt + 4'h1 : 4'h0;
            // causes held until the device runs again, as a level source would
            if (fire) begin
                {irq_pending, ext_wake_pin, pd_wake_irq} <= 3'h4 >> (wake_kind - 2'h1);
            end else if (pmc_state == pmc_pkg::PMC_RUN) begin
                {irq_pending, ext_wake_pin, pd_wake_irq} <= 3'h0;
            end
        end
    end
endmodule : pmc_far_model

// File: bench/pmc_power_ctrl_tb.sv
// self-checking bench of the power control block
`timescale 1ns/1ns
`include "pmc_params.svh"
module pmc_power_ctrl_tb;
    logic core_clk = 1'b0, rst = 1'b1, por_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rv;
    logic frame_error = 1'b0, serial_mode0 = 1'b0, port4_ovr_en = 1'b0, port4_b7_out = 1'b0;
    logic clk_out_en = 1'b0, watchdog_idle_enable = 1'b0, frame_err_clr = 1'b0;
    logic [1:0] serial_mode = 2'h0, clk_src = 2'h0, wake_kind = 2'h0;
    logic [3:0] clk_div = 4'h0, lag = 4'h2;
    logic sfr_hit, irq_pending, pd_wake_irq, ext_wake_pin, serial_control_reg_bit7, frame_error_flag;
    logic baud_double, amp_en, core_en, periph_en, watchdog_en, brownout_detector_en;
    logic flash_pwr_en, ram_retain, irq_service_now, osc_out_pin_o, osc_out_pin_oe_n;
    logic osc_in_is_gpio, osc_out_is_gpio;
    pmc_pkg::pmc_state_t pmc_state;
    int failures = 0, n_checks = 0, cycles = 0, n;
    always #5 core_clk = ~core_clk;
    pmc_power_ctrl dut (.core_clk, .rst(rst || por_rst), .por_rst, .sfr_addr, .sfr_wdata,
        .sfr_wr, .sfr_rd, .sfr_rdata, .sfr_hit, .irq_pending, .pd_wake_irq, .ext_wake_pin,
        .frame_error, .serial_mode0, .serial_mode, .clk_src, .clk_div, .port4_ovr_en,
        .port4_b7_out, .clk_out_en, .watchdog_idle_enable, .frame_err_clr, .serial_control_reg_bit7,
        .frame_error_flag, .baud_double, .amp_en, .core_en, .periph_en, .watchdog_en,
        .brownout_detector_en, .flash_pwr_en, .ram_retain, .irq_service_now, .osc_out_pin_o,
        .osc_out_pin_oe_n, .osc_in_is_gpio, .osc_out_is_gpio, .pmc_state);
    pmc_far_model partner (.core_clk, .rst(rst || por_rst), .pmc_state, .wake_kind, .lag,
        .irq_pending, .pd_wake_irq, .ext_wake_pin);
    task automatic final_report();
        if (failures == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1 rv = sfr_rdata;
    endtask : rd
    task automatic wait_st(input pmc_pkg::pmc_state_t s, input int lim);
        n = 0;
        while (pmc_state !== s && n < lim) begin
            step(1);
            n++;
        end
        chk("pmc_state", 8'(pmc_state), 8'(s));
    endtask : wait_st
    task automatic rst_pulse(input logic cold);
        @(posedge core_clk);
        rst <= 1'b1;
        por_rst <= cold;
        step(2);
        rst <= 1'b0;
        por_rst <= 1'b0;
    endtask : rst_pulse
    task automatic t_regs();
        rd(8'h87); chk("cold", rv, 8'h10);
        rd(8'h86); chk("unmapped", rv, 8'h00);
        wr(8'h87, 8'hEC); wr(8'h86, 8'hFF);
        rd(8'h87); chk("flags", rv, 8'hEC);
        rst_pulse(1'b0); rd(8'h87); chk("warm0", rv, 8'h00);
        wr(8'h87, 8'h1C); rst_pulse(1'b0);
        rd(8'h87); chk("warm1", rv, 8'h10);
        wr(8'h87, 8'h00); rst_pulse(1'b1);
        rd(8'h87); chk("cold2", rv, 8'h10);
    endtask : t_regs
    task automatic fe_pulse(input logic clr);
        @(posedge core_clk);
        frame_error <= !clr;
        frame_err_clr <= clr;
        @(posedge core_clk);
        {frame_error, frame_err_clr} <= 2'h0;
        step(2);
    endtask : fe_pulse
    task automatic t_serial();
        wr(8'h87, 8'h80);
        for (int m = 0; m < 4; m++) begin
            serial_mode <= 2'(m); step(1);
            chk("baud", 8'(baud_double), 8'(m != 0));
        end
        wr(8'h87, 8'h40); serial_mode0 <= 1'b0; fe_pulse(1'b0);
        chk("fe_view", 8'(serial_control_reg_bit7), 8'h01);
        fe_pulse(1'b1); chk("fe_clr", 8'(serial_control_reg_bit7), 8'h00);
        wr(8'h87, 8'h00); fe_pulse(1'b0);
        chk("fe_flag", 8'(frame_error_flag), 8'h01);
        chk("sm0_view", 8'(serial_control_reg_bit7), 8'h00);
    endtask : t_serial
    task automatic t_idle();
        wake_kind <= 2'h1; lag <= 4'h3; wr(8'h87, 8'h01);
        wait_st(pmc_pkg::PMC_IDLE, 10);
        chk("gates", 8'({core_en, periph_en, brownout_detector_en, watchdog_en}), 8'h06);
        wait_st(pmc_pkg::PMC_RUN, 20);
        chk("serve", 8'(irq_service_now), 8'h01);
        rd(8'h87); chk("idle_clr", rv, 8'h00);
        wake_kind <= 2'h0; watchdog_idle_enable <= 1'b1; wr(8'h87, 8'h01);
        wait_st(pmc_pkg::PMC_IDLE, 10); chk("wdt", 8'(watchdog_en), 8'h01);
        rst_pulse(1'b0); chk("rst_exit", 8'(pmc_state), 8'(pmc_pkg::PMC_RUN));
    endtask : t_idle
    task automatic t_pdown();
        wake_kind <= 2'h2; wr(8'h87, 8'h02);
        wait_st(pmc_pkg::PMC_PDOWN, 10);
        chk("pd_off", 8'({flash_pwr_en, brownout_detector_en, amp_en, ram_retain}), 8'h01);
        wait_st(pmc_pkg::PMC_RUN, 20);
        rd(8'h87); chk("pd_clr", rv, 8'h00);
        wake_kind <= 2'h3; wr(8'h87, 8'h22);
        wait_st(pmc_pkg::PMC_PDOWN, 10); wait_st(pmc_pkg::PMC_WAKE, 20);
        wait_st(pmc_pkg::PMC_RUN, 200);
        chk("wake_len", 8'(n >= `PMC_WAKE_CYCLES - 1 && n <= `PMC_WAKE_CYCLES + 2), 8'h01);
        rd(8'h87); chk("pd_clr2", rv, 8'h20);
    endtask : t_pdown
    task automatic t_clock();
        clk_src <= 2'h1; clk_out_en <= 1'b1; step(1);
        chk("ext_amp", 8'(amp_en), 8'h00);
        chk("clk_out", 8'(osc_out_pin_oe_n), 8'h00);
        clk_out_en <= 1'b0; port4_ovr_en <= 1'b1; port4_b7_out <= 1'b1; step(1);
        chk("p47", 8'(osc_out_is_gpio), 8'h01);
        chk("p47_out", 8'(osc_out_pin_o), 8'h01);
        clk_src <= 2'h2; port4_ovr_en <= 1'b0; step(1);
        chk("rc_pins", 8'({osc_in_is_gpio, osc_out_is_gpio}), 8'h03);
        // divide by two: peripheral enable must alternate
        clk_div <= 4'h1; step(2);
        rv = 8'(periph_en);
        step(1);
        chk("div", 8'(rv[0] ^ periph_en), 8'h01);
        clk_div <= 4'h0;
    endtask : t_clock
    always @(posedge core_clk) begin
        cycles++;
        // generous ceiling; the whole sequence needs well under a thousand cycles
        if (cycles == 5000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        step(10);
        rst <= 1'b0;
        por_rst <= 1'b0;
        t_regs();
        t_serial();
        t_idle();
        t_pdown();
        t_clock();
        final_report();
    end
endmodule : pmc_power_ctrl_tb
